// ==== hdl/mcr_pkg.sv ====
// constants, field layout and profile values of the modem call configuration bank
// assumes one 10 MHz system clock and word-aligned AXI4-Lite register access
package mcr_pkg;

  // =====================================================
  // timing
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned DIAL_WAIT_S   = 5;
  localparam int unsigned DIAL_WAIT_CYC = DIAL_WAIT_S * CLK_HZ;

  // =====================================================
  // register byte addresses
  localparam int         ADDR_W      = 6;
  localparam logic [5:0] OFS_SPARE_A = 6'h00;
  localparam logic [5:0] OFS_SPARE_B = 6'h04;
  localparam logic [5:0] OFS_CALL    = 6'h08;
  localparam logic [5:0] OFS_GUARD   = 6'h0C;
  localparam logic [5:0] OFS_EQ      = 6'h10;
  localparam logic [5:0] OFS_TXFMT   = 6'h14;
  localparam logic [5:0] OFS_GENOPT  = 6'h18;
  localparam logic [5:0] OFS_PROFILE = 6'h1C;
  localparam logic [5:0] OFS_STATUS  = 6'h20;

  // =====================================================
  // writable bits of the call, equaliser and general option registers
  localparam logic [7:0] MSK_CALL = 8'h07;
  localparam logic [7:0] MSK_EQ   = 8'h0F;
  localparam logic [7:0] MSK_GEN  = 8'h8F;

  // =====================================================
  // profile zero (power-up) and profile one values
  localparam logic [7:0] P0_CALL  = 8'h00;
  localparam logic [7:0] P0_GUARD = 8'h00;
  localparam logic [7:0] P0_EQ    = 8'h01;
  localparam logic [7:0] P0_TXFMT = 8'hB0;
  localparam logic [7:0] P0_GEN   = 8'h85;
  localparam logic [7:0] P1_CALL  = 8'h00;
  localparam logic [7:0] P1_GUARD = 8'h00;
  localparam logic [7:0] P1_EQ    = 8'h00;
  localparam logic [7:0] P1_TXFMT = 8'hB0;
  localparam logic [7:0] P1_GEN   = 8'h80;

  // =====================================================
  // field positions
  localparam int CALL_DIAL_BIT  = 0;
  localparam int CALL_BUSY_BIT  = 1;
  localparam int CALL_SPEED_BIT = 2;
  localparam int EQ_WORD_BIT    = 0;
  localparam int EQ_FIXDIS_BIT  = 1;
  localparam int EQ_ADAPT_BIT   = 2;
  localparam int EQ_FALL_BIT    = 3;
  localparam int GEN_ORIG_BIT   = 7;
  localparam int TX_ATT_HI      = 2;
  localparam int TX_STOP_BIT    = 3;
  localparam int TX_LEN_LO      = 4;
  localparam int TX_LEN_HI      = 5;

  // =====================================================
  // codes
  localparam logic [7:0] GT_NONE  = 8'h00;
  localparam logic [7:0] GT_1800  = 8'h02;
  localparam logic [7:0] GT_550   = 8'h03;
  localparam logic [1:0] TAG_ASYNC = 2'h2;
  localparam logic [4:0] TAG_SYNC  = 5'h1F;
  localparam logic [4:0] TAG_HDLC  = 5'h0F;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {MODE_ASYNC, MODE_SYNC, MODE_HDLC, MODE_BAD} mcr_txmode_t;

  // framing tag of a transmit format byte
  function automatic mcr_txmode_t mcr_tx_mode(input logic [7:0] v);
    if (v[7:6] == TAG_ASYNC) begin
      return MODE_ASYNC;
    end else if (v[7:3] == TAG_SYNC) begin
      return MODE_SYNC;
    end else if (v[7:3] == TAG_HDLC) begin
      return MODE_HDLC;
    end
    return MODE_BAD;
  endfunction

  // guard tone codes other than these three are refused
  function automatic logic mcr_guard_ok(input logic [7:0] v);
    return (v == GT_NONE) || (v == GT_1800) || (v == GT_550);
  endfunction

endpackage

// ==== hdl/mcr_axil_slave.sv ====
// AXI4-Lite slave front end: one read in flight at most; a second write is held while a write response waits
// assumes the bank answers rd_data/rd_err and wr_err combinationally
`timescale 1ns/10ps
module mcr_axil_slave
  import mcr_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              nrst,
  // AXI4-Lite
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // bank side
  output logic                   wr_en,
  output logic [ADDR_W-1:0]      wr_addr,
  output logic [7:0]             wr_data,
  input  wire logic              wr_err,
  output logic [ADDR_W-1:0]      rd_addr,
  input  wire logic [7:0]        rd_data,
  input  wire logic              rd_err
);

  logic              aw_held_ff;
  logic              w_held_ff;
  logic [ADDR_W-1:0] aw_addr_ff;
  logic [7:0]        w_data_ff;
  logic              w_lane_ff;
  logic              nxt_aw_held;
  logic              nxt_w_held;
  logic              nxt_bvalid;

  // =====================================================
  // write channel: address and data taken in either order
  always_comb begin
    nxt_aw_held = aw_held_ff | (awvalid & awready);
    nxt_w_held  = w_held_ff | (wvalid & wready);
    nxt_bvalid  = bvalid & ~bready;
    if (wr_en) begin
      nxt_aw_held = 1'b0;
      nxt_w_held  = 1'b0;
      nxt_bvalid  = 1'b1;
    end
  end

  // strobe only when both halves are held and no response waits
  assign wr_en   = aw_held_ff & w_held_ff & w_lane_ff & ~bvalid;
  assign wr_addr = aw_addr_ff;
  assign wr_data = w_data_ff;

  // write holding registers and response
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
      aw_addr_ff <= '0;
      w_data_ff  <= 8'h00;
      w_lane_ff  <= 1'b0;
      awready    <= 1'b0;
      wready     <= 1'b0;
      bvalid     <= 1'b0;
      bresp      <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_addr_ff <= awaddr;
      end
      if (wvalid && wready) begin
        w_data_ff <= wdata[7:0];
        w_lane_ff <= wstrb[0];
      end
      // a write without the low lane still answers, but stores nothing
      if (aw_held_ff && w_held_ff && !bvalid) begin
        bresp <= (w_lane_ff && wr_err) ? RESP_SLVERR : RESP_OKAY;
      end
      aw_held_ff <= (aw_held_ff && w_held_ff && !bvalid) ? 1'b0 : nxt_aw_held;
      w_held_ff  <= (aw_held_ff && w_held_ff && !bvalid) ? 1'b0 : nxt_w_held;
      bvalid     <= (aw_held_ff && w_held_ff && !bvalid) ? 1'b1 : nxt_bvalid;
      awready    <= ~nxt_aw_held & ~(aw_held_ff & w_held_ff);
      wready     <= ~nxt_w_held & ~(aw_held_ff & w_held_ff);
    end
  end

  // =====================================================
  // read channel: data latched at the address handshake
  assign rd_addr = araddr;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= {24'h00_0000, rd_data};
      rresp   <= rd_err ? RESP_SLVERR : RESP_OKAY;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end else begin
      arready <= ~rvalid;
    end
  end

  chk_bresp_holds: assert property (@(posedge clk) disable iff (!nrst)
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before it was taken");
  chk_read_answer: assert property (@(posedge clk) disable iff (!nrst)
    arvalid && arready |=> rvalid && !arready)
    else $error("read data not offered one cycle after address");

endmodule

// ==== hdl/mcr_tone_wait.sv ====
// dial tone wait: holds back dialling until tone is heard or the wait runs out
// assumes the tone detector pin is asynchronous to the system clock
`timescale 1ns/10ps
module mcr_tone_wait #(
  parameter int unsigned WAIT_CYC = 100
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // control
  input  wire logic en,
  input  wire logic start,
  input  wire logic tone_pin,
  // result
  output logic      go,
  output logic      timed_out,
  output logic      waiting
);

  localparam int CW = $clog2(WAIT_CYC + 1);

  typedef enum logic {ST_IDLE, ST_WAIT} mcr_wait_t;

  mcr_wait_t     state_ff;
  logic [CW-1:0] cnt_ff;
  logic          sync1_ff;
  logic          sync2_ff;
  logic          sync3_ff;
  logic          tone_ff;

  // =====================================================
  // three-stage synchroniser; level moves only when stages two and three agree
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      sync3_ff <= 1'b0;
      tone_ff  <= 1'b0;
    end else begin
      sync1_ff <= tone_pin;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      if (sync2_ff == sync3_ff) begin
        tone_ff <= sync3_ff;
      end
    end
  end

  // =====================================================
  // wait sequence; a start while waiting is ignored
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_ff  <= ST_IDLE;
      cnt_ff    <= '0;
      go        <= 1'b0;
      timed_out <= 1'b0;
    end else begin
      go <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          if (start && !en) begin
            go        <= 1'b1; // dial tone ignored
            timed_out <= 1'b0;
          end else if (start) begin
            state_ff <= ST_WAIT; // wait for tone
            cnt_ff   <= '0;
          end
        end
        ST_WAIT: begin
          if (tone_ff) begin
            go        <= 1'b1;
            timed_out <= 1'b0;
            state_ff  <= ST_IDLE;
          end else if (cnt_ff == CW'(WAIT_CYC - 1)) begin
            go        <= 1'b1; // dial anyway after the limit
            timed_out <= 1'b1;
            state_ff  <= ST_IDLE;
          end else begin
            cnt_ff <= cnt_ff + 1'b1;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  assign waiting = (state_ff == ST_WAIT);

  chk_dial_bypass: assert property (@(posedge clk) disable iff (!nrst)
    start && !en && state_ff == ST_IDLE |=> go && !timed_out)
    else $error("dial not released at once with tone wait off");
  chk_wait_bound: assert property (@(posedge clk) disable iff (!nrst)
    state_ff == ST_WAIT |-> cnt_ff < CW'(WAIT_CYC))
    else $error("dial tone wait ran past its limit");

endmodule

// ==== hdl/mcr_top.sv ====
// modem call configuration bank: byte registers reached over AXI4-Lite
// assumes one 10 MHz clock; the controller reads the decoded settings as levels
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
module mcr_top
  import mcr_pkg::*;
#(
  parameter int unsigned DIAL_WAIT_CYCLES = DIAL_WAIT_CYC
) (
  // clock and reset
  input  wire logic              MCLK,
  input  wire logic              NRST,
  // AXI4-Lite write
  input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input  wire logic              S_AXI_AWVALID,
  output logic                   S_AXI_AWREADY,
  input  wire logic [31:0]       S_AXI_WDATA,
  input  wire logic [3:0]        S_AXI_WSTRB,
  input  wire logic              S_AXI_WVALID,
  output logic                   S_AXI_WREADY,
  output logic [1:0]             S_AXI_BRESP,
  output logic                   S_AXI_BVALID,
  input  wire logic              S_AXI_BREADY,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input  wire logic              S_AXI_ARVALID,
  output logic                   S_AXI_ARREADY,
  output logic [31:0]            S_AXI_RDATA,
  output logic [1:0]             S_AXI_RRESP,
  output logic                   S_AXI_RVALID,
  input  wire logic              S_AXI_RREADY,
  // dialling
  input  wire logic              DIAL_REQ,
  input  wire logic              DIAL_TONE_DET,
  output logic                   DIAL_GO,
  // calling options
  output logic                   DIAL_WAIT_EN,
  output logic                   BUSY_WAIT_EN,
  output logic                   REPORT_SPEED,
  output logic                   ORIGINATE,
  output logic [1:0]             GUARD_SEL,
  // modem configuration
  output logic                   WORD_MODE,
  output logic                   FIXED_EQ_EN,
  output logic                   ADAPT_EQ_EN,
  output logic                   FALLBACK_EN,
  // transmit format
  output logic [1:0]             TX_MODE,
  output logic [2:0]             TX_ATTEN,
  output logic [1:0]             TX_DATA_LEN,
  output logic                   TX_TWO_STOP
);

  logic [7:0]        call_ff;
  logic [7:0]        guard_ff;
  logic [7:0]        eq_ff;
  logic [7:0]        txfmt_ff;
  logic [7:0]        gen_ff;
  logic              profile_ff;
  logic              wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [7:0]        wr_data;
  logic              wr_err;
  logic [ADDR_W-1:0] rd_addr;
  logic [7:0]        rd_data;
  logic              rd_err;
  logic              dial_go;
  logic              dial_late;
  logic              dial_wait;
  logic [ADDR_W-1:0] wr_word;
  logic [ADDR_W-1:0] rd_word;

  // =====================================================
  // bus front end
  mcr_axil_slave u_bus (
    .clk     (MCLK),
    .nrst    (NRST),
    .awaddr  (S_AXI_AWADDR),
    .awvalid (S_AXI_AWVALID),
    .awready (S_AXI_AWREADY),
    .wdata   (S_AXI_WDATA),
    .wstrb   (S_AXI_WSTRB),
    .wvalid  (S_AXI_WVALID),
    .wready  (S_AXI_WREADY),
    .bresp   (S_AXI_BRESP),
    .bvalid  (S_AXI_BVALID),
    .bready  (S_AXI_BREADY),
    .araddr  (S_AXI_ARADDR),
    .arvalid (S_AXI_ARVALID),
    .arready (S_AXI_ARREADY),
    .rdata   (S_AXI_RDATA),
    .rresp   (S_AXI_RRESP),
    .rvalid  (S_AXI_RVALID),
    .rready  (S_AXI_RREADY),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .wr_err  (wr_err),
    .rd_addr (rd_addr),
    .rd_data (rd_data),
    .rd_err  (rd_err)
  );

  // =====================================================
  // dial tone wait
  mcr_tone_wait #(
    .WAIT_CYC (DIAL_WAIT_CYCLES)
  ) u_dial (
    .clk       (MCLK),
    .nrst      (NRST),
    .en        (call_ff[CALL_DIAL_BIT]),
    .start     (DIAL_REQ),
    .tone_pin  (DIAL_TONE_DET),
    .go        (dial_go),
    .timed_out (dial_late),
    .waiting   (dial_wait)
  );

  // =====================================================
  // address decode: low two address bits are ignored
  assign wr_word = {wr_addr[ADDR_W-1:2], 2'b00};
  assign rd_word = {rd_addr[ADDR_W-1:2], 2'b00};

  // refuse unmapped offsets and values that cannot be stored
  always_comb begin
    wr_err = 1'b0;
    case (wr_word)
      OFS_SPARE_A, OFS_SPARE_B, OFS_CALL, OFS_EQ, OFS_GENOPT, OFS_PROFILE,
      OFS_STATUS: wr_err = 1'b0;
      OFS_GUARD:  wr_err = ~mcr_guard_ok(wr_data);
      OFS_TXFMT:  wr_err = (mcr_tx_mode(wr_data) == MODE_BAD);
      default:    wr_err = 1'b1;
    endcase
  end

  // read mux; spare registers and reserved bits give zero
  always_comb begin
    rd_data = 8'h00;
    rd_err  = 1'b0;
    case (rd_word)
      OFS_SPARE_A: rd_data = 8'h00;
      OFS_SPARE_B: rd_data = 8'h00;
      OFS_CALL:    rd_data = call_ff;
      OFS_GUARD:   rd_data = guard_ff;
      OFS_EQ:      rd_data = eq_ff;
      OFS_TXFMT:   rd_data = txfmt_ff;
      OFS_GENOPT:  rd_data = gen_ff;
      OFS_PROFILE: rd_data = {7'h00, profile_ff};
      OFS_STATUS:  rd_data = {4'h0, mcr_tx_mode(txfmt_ff), dial_late, dial_wait};
      default:     rd_err  = 1'b1;
    endcase
  end

  // =====================================================
  // register bank; illegal values leave the old content in place
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      call_ff    <= P0_CALL; // power-up profile
      guard_ff   <= P0_GUARD;
      eq_ff      <= P0_EQ;
      txfmt_ff   <= P0_TXFMT;
      gen_ff     <= P0_GEN;
      profile_ff <= 1'b0;
    end else if (wr_en && !wr_err) begin
      case (wr_word)
        OFS_CALL:   call_ff  <= wr_data & MSK_CALL;
        OFS_GUARD:  guard_ff <= wr_data;
        OFS_EQ:     eq_ff    <= wr_data & MSK_EQ; // upper nibble reserved
        OFS_TXFMT:  txfmt_ff <= wr_data;
        OFS_GENOPT: gen_ff   <= wr_data & MSK_GEN;
        OFS_PROFILE: begin
          profile_ff <= wr_data[0];
          // whole profile loaded in one edge
          call_ff  <= wr_data[0] ? P1_CALL : P0_CALL;
          guard_ff <= wr_data[0] ? P1_GUARD : P0_GUARD;
          eq_ff    <= wr_data[0] ? P1_EQ : P0_EQ;
          txfmt_ff <= wr_data[0] ? P1_TXFMT : P0_TXFMT;
          gen_ff   <= wr_data[0] ? P1_GEN : P0_GEN;
        end
        default: profile_ff <= profile_ff; // spares and status are inert
      endcase
    end
  end

  // =====================================================
  // calling outputs, registered so every pin comes from a flop
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      DIAL_GO      <= 1'b0;
      DIAL_WAIT_EN <= 1'b0;
      BUSY_WAIT_EN <= 1'b0;
      REPORT_SPEED <= 1'b0;
      ORIGINATE    <= 1'b0;
      GUARD_SEL    <= 2'h0;
    end else begin
      DIAL_GO      <= dial_go;
      DIAL_WAIT_EN <= call_ff[CALL_DIAL_BIT];
      // busy tone wait is only passed on; nothing acts on it yet
      BUSY_WAIT_EN <= call_ff[CALL_BUSY_BIT];
      REPORT_SPEED <= call_ff[CALL_SPEED_BIT];
      ORIGINATE    <= gen_ff[GEN_ORIG_BIT];
      GUARD_SEL    <= guard_ff[1:0]; // tone used only in high band
    end
  end

  // modem configuration outputs
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      WORD_MODE   <= 1'b0;
      FIXED_EQ_EN <= 1'b0;
      ADAPT_EQ_EN <= 1'b0;
      FALLBACK_EN <= 1'b0;
    end else begin
      WORD_MODE   <= eq_ff[EQ_WORD_BIT];
      FIXED_EQ_EN <= ~eq_ff[EQ_FIXDIS_BIT];
      ADAPT_EQ_EN <= eq_ff[EQ_ADAPT_BIT];
      FALLBACK_EN <= eq_ff[EQ_FALL_BIT];
    end
  end

  // transmit format outputs; length and stop bits mean nothing outside async
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      TX_MODE     <= MODE_ASYNC;
      TX_ATTEN    <= 3'h0;
      TX_DATA_LEN <= 2'h0;
      TX_TWO_STOP <= 1'b0;
    end else begin
      TX_MODE     <= mcr_tx_mode(txfmt_ff);
      TX_ATTEN    <= txfmt_ff[TX_ATT_HI:0]; // same in every mode
      TX_DATA_LEN <= txfmt_ff[TX_LEN_HI:TX_LEN_LO];
      TX_TWO_STOP <= txfmt_ff[TX_STOP_BIT];
    end
  end

  // spare registers must always read zero; helper for the checks below
  function automatic logic spare_zero(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    return !((a == OFS_SPARE_A || a == OFS_SPARE_B) && d != 8'h00);
  endfunction

  // =====================================================
  // checks
  // pins checked against $past register values are compared only from the second edge after reset, since the
  // edge that releases reset still loads the reset zeros into them
  chk_guard_legal: assert property (@(posedge MCLK) disable iff (!NRST)
    mcr_guard_ok(guard_ff) && GUARD_SEL != 2'h1)
    else $error("guard tone holds an illegal code");
  chk_tx_tag_legal: assert property (@(posedge MCLK) disable iff (!NRST)
    mcr_tx_mode(txfmt_ff) != MODE_BAD)
    else $error("transmit format lost its framing tag");
  chk_eq_reserved: assert property (@(posedge MCLK) disable iff (!NRST)
    eq_ff[7:4] == 4'h0 && spare_zero(rd_word, rd_data))
    else $error("reserved bits do not read zero");
  chk_fixed_eq: assert property (@(posedge MCLK) disable iff (!NRST)
    $past(NRST) |-> FIXED_EQ_EN == ~$past(eq_ff[EQ_FIXDIS_BIT])
    && ADAPT_EQ_EN == $past(eq_ff[EQ_ADAPT_BIT]))
    else $error("equaliser enables do not follow the register");
  chk_atten_out: assert property (@(posedge MCLK) disable iff (!NRST)
    $past(NRST) |-> TX_ATTEN == $past(txfmt_ff[TX_ATT_HI:0])
    && TX_DATA_LEN == $past(txfmt_ff[TX_LEN_HI:TX_LEN_LO]))
    else $error("transmit format outputs do not follow the register");
  chk_profile_one: assert property (@(posedge MCLK) disable iff (!NRST)
    wr_en && wr_word == OFS_PROFILE && wr_data[0]
    |=> eq_ff == P1_EQ && gen_ff == P1_GEN && txfmt_ff == P1_TXFMT && call_ff == P1_CALL)
    else $error("profile one not loaded as a whole");
  chk_originate: assert property (@(posedge MCLK) disable iff (!NRST)
    wr_en && !wr_err && wr_word == OFS_GENOPT |=> ##1 ORIGINATE == $past(wr_data[7], 2))
    else $error("call role does not follow general options");
  chk_call_bits: assert property (@(posedge MCLK) disable iff (!NRST)
    $past(NRST) |-> DIAL_WAIT_EN == $past(call_ff[CALL_DIAL_BIT])
    && BUSY_WAIT_EN == $past(call_ff[CALL_BUSY_BIT]))
    else $error("tone wait enables do not follow calling mode");
  chk_speed_report: assert property (@(posedge MCLK) disable iff (!NRST)
    $past(NRST) |-> REPORT_SPEED == $past(call_ff[CALL_SPEED_BIT]))
    else $error("speed report does not follow calling mode");
  chk_word_fallback: assert property (@(posedge MCLK) disable iff (!NRST)
    $past(NRST) |-> WORD_MODE == $past(eq_ff[EQ_WORD_BIT])
    && FALLBACK_EN == $past(eq_ff[EQ_FALL_BIT]))
    else $error("word mode or fallback does not follow the register");
  chk_tx_mode_out: assert property (@(posedge MCLK) disable iff (!NRST)
    $past(NRST) |-> TX_MODE == mcr_tx_mode($past(txfmt_ff))
    && TX_TWO_STOP == $past(txfmt_ff[TX_STOP_BIT]))
    else $error("transmit mode or stop bits do not follow the register");
  chk_guard_out: assert property (@(posedge MCLK) disable iff (!NRST)
    $past(NRST) |-> GUARD_SEL == $past(guard_ff[1:0]))
    else $error("guard tone output does not follow the register");
  chk_dial_go_lag: assert property (@(posedge MCLK) disable iff (!NRST)
    dial_go |=> DIAL_GO)
    else $error("dial release not passed to the pin");

endmodule

// ==== tb/mcr_tone_src.sv ====
// dial tone source on the line side of the tone detector
// assumes the bench raises on while a tone should be heard
`timescale 1ns/10ps
module mcr_tone_src (
  // clock, reset, control
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic on,
  // detector pin, idle low
  output logic      tone
);
  logic [3:0] cnt_ff;
  // =========================
  // tone builds up over cycles, never at once
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_ff <= 4'h0;
    end else begin
      cnt_ff <= on ? cnt_ff + 4'(cnt_ff != 4'hF) : 4'h0;
    end
  end
  assign tone = (cnt_ff > 4'h6);
endmodule

// ==== tb/mcr_top_tb_top.sv ====
// self-checking bench of the configuration bank
// assumes mcr_pkg and mcr_top compiled first
`timescale 1ns/10ps
module mcr_top_tb_top;
  import mcr_pkg::*;
  logic        MCLK = 1'b0, NRST = 1'b0, tone_on = 1'b0, DIAL_REQ = 1'b0;
  logic [5:0]  S_AXI_AWADDR = 6'h00, S_AXI_ARADDR = 6'h00;
  logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA;
  logic [3:0]  S_AXI_WSTRB = 4'hF;
  logic        S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
  logic        S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
  logic        S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, GUARD_SEL, TX_MODE, TX_DATA_LEN;
  logic        DIAL_TONE_DET, DIAL_GO, DIAL_WAIT_EN, BUSY_WAIT_EN, REPORT_SPEED, ORIGINATE;
  logic        WORD_MODE, FIXED_EQ_EN, ADAPT_EQ_EN, FALLBACK_EN, TX_TWO_STOP;
  logic [2:0]  TX_ATTEN;
  int          miscompares = 0, cmp_count = 0, cyc = 0;

  // short dial wait keeps the run brief
  mcr_top #(.DIAL_WAIT_CYCLES(20)) dut (.*);
  mcr_tone_src tsrc (.clk(MCLK), .nrst(NRST), .on(tone_on), .tone(DIAL_TONE_DET));

  // =========================
  // clock, timeout, verdict
  initial forever #50 MCLK = ~MCLK;
  always @(posedge MCLK) begin
    cyc++;
    if (cyc > 5000) begin
      miscompares++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED %s exp %h seen %h", n, e, s);
    end
  endtask

  // =========================
  // bus master: halves offered together, each dropped once taken
  task automatic wrc(input logic [5:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge MCLK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= {24'h0, d};
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    do begin
      @(posedge MCLK);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
    end while (S_AXI_BVALID !== 1'b1);
    S_AXI_BREADY <= 1'b0;
    chk("bresp", 8'(er), 8'(S_AXI_BRESP));
  endtask
  task automatic rdc(input logic [5:0] a, input logic [7:0] e, input string n);
    @(posedge MCLK);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    do begin
      @(posedge MCLK);
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
    end while (S_AXI_RVALID !== 1'b1);
    S_AXI_RREADY <= 1'b0;
    chk(n, e, S_AXI_RDATA[7:0]);
    chk("rresp", 8'((a >= 6'h24) ? RESP_SLVERR : RESP_OKAY), 8'(S_AXI_RRESP));
  endtask
  // decoded outputs lag the register by a clock
  task automatic settle();
    repeat (2) @(posedge MCLK);
  endtask

  // =========================
  // scenarios
  task automatic t_regs();
    logic [7:0] tx[4] = '{8'h9D, 8'hFA, 8'h7B, 8'h40};
    logic [7:0] ox[4] = '{8'h2B, 8'h57, 8'h9F, 8'h9F};
    rdc(OFS_EQ, P0_EQ, "eq rst");
    rdc(OFS_TXFMT, P0_TXFMT, "tx rst");
    chk("eq outs", 8'h0C, 8'({WORD_MODE, FIXED_EQ_EN, ADAPT_EQ_EN, FALLBACK_EN}));
    wrc(OFS_CALL, 8'hFF, RESP_OKAY);
    rdc(OFS_CALL, 8'h07, "call");
    wrc(OFS_CALL, 8'h05, RESP_OKAY);
    settle();
    chk("call outs", 8'h05, 8'({DIAL_WAIT_EN, BUSY_WAIT_EN, REPORT_SPEED}));
    for (int i = 0; i < 4; i++) begin
      wrc(OFS_GUARD, 8'(i), (i == 1) ? RESP_SLVERR : RESP_OKAY);
      settle();
      chk("guard", (i == 1) ? 8'h00 : 8'(i), 8'(GUARD_SEL));
    end
    wrc(OFS_EQ, 8'hFA, RESP_OKAY);
    rdc(OFS_EQ, 8'h0A, "eq rsvd");
    chk("eq outs", 8'h01, 8'({WORD_MODE, FIXED_EQ_EN, ADAPT_EQ_EN, FALLBACK_EN}));
    wrc(OFS_EQ, 8'h05, RESP_OKAY);
    settle();
    chk("eq outs", 8'h0E, 8'({WORD_MODE, FIXED_EQ_EN, ADAPT_EQ_EN, FALLBACK_EN}));
    for (int i = 0; i < 4; i++) begin
      wrc(OFS_TXFMT, tx[i], (i == 3) ? RESP_SLVERR : RESP_OKAY);
      settle();
      chk("tx outs", ox[i], {TX_MODE, TX_ATTEN, TX_DATA_LEN, TX_TWO_STOP});
    end
    $display("register test done");
  endtask
  task automatic t_prof();
    wrc(OFS_GENOPT, 8'h7F, RESP_OKAY);
    rdc(OFS_GENOPT, 8'h0F, "genopt");
    chk("originate", 8'h00, 8'(ORIGINATE));
    wrc(OFS_SPARE_A, 8'hFF, RESP_OKAY);
    rdc(OFS_SPARE_A, 8'h00, "spare");
    wrc(6'h24, 8'h01, RESP_SLVERR);
    rdc(6'h24, 8'h00, "unmapped");
    wrc(OFS_PROFILE, 8'h01, RESP_OKAY);
    rdc(OFS_EQ, P1_EQ, "eq p1");
    rdc(OFS_GENOPT, P1_GEN, "gen p1");
    chk("originate", 8'h01, 8'(ORIGINATE));
    wrc(OFS_PROFILE, 8'h00, RESP_OKAY);
    rdc(OFS_GENOPT, P0_GEN, "gen p0");
    $display("profile test done");
  endtask
  // cycles from request to go, for wait off, tone heard, no tone
  task automatic t_dial();
    int n;
    for (int k = 0; k < 3; k++) begin
      wrc(OFS_CALL, 8'(k != 0), RESP_OKAY);
      settle();
      tone_on <= (k == 1);
      DIAL_REQ <= 1'b1;
      @(posedge MCLK);
      DIAL_REQ <= 1'b0;
      n = 0;
      do begin
        @(posedge MCLK);
        #1;
        n++;
      end while (DIAL_GO !== 1'b1 && n < 60);
      chk("dial delay", 8'h01, 8'((k == 0) ? (n == 1) : (k == 1) ? (n < 19) : (n == 21)));
      tone_on <= 1'b0;
      repeat (4) @(posedge MCLK);
    end
    // last dial ran out of time, nothing waiting, async framing
    rdc(OFS_STATUS, 8'h02, "status");
    $display("dial test done");
  endtask

  initial begin
    repeat (3) @(posedge MCLK);
    NRST <= 1'b1;
    t_regs();
    t_prof();
    t_dial();
    finish_test();
  end
endmodule
